// ==== logic/adss_pkg.sv ====
`default_nettype none
package adss_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [2:0] RESULT_PAGE = 3'h1;
	localparam logic [7:0] OFF_RESULT0 = 8'h20;

	// ------------------------------------------------------------
	// Control register fields
	// ------------------------------------------------------------
	localparam int CTRL_START_POS = 0;
	localparam int CTRL_MODE_POS = 1;
	localparam int CTRL_SEL_LO_POS = 3;
	localparam int CTRL_SEL_HI_POS = 4;
	localparam int CTRL_RES_POS = 5;
	localparam int CTRL_DIV_POS = 6;
	localparam int CTRL_VREF_POS = 8;
	localparam int CTRL_W = 9;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h000;

	// ------------------------------------------------------------
	// Status register fields
	// ------------------------------------------------------------
	localparam int STAT_IRQ_POS = 0;
	localparam int STAT_BUSY_POS = 1;
	localparam int STAT_CH_POS = 4;

	// ------------------------------------------------------------
	// Sweep modes and divider choices
	// ------------------------------------------------------------
	localparam logic [1:0] MODE_SINGLE = 2'h0;
	localparam logic [1:0] MODE_REPEAT0 = 2'h1;
	localparam logic [1:0] MODE_REPEAT1 = 2'h2;
	localparam logic [1:0] DIV_BY4 = 2'h0;
	localparam logic [1:0] DIV_BY3 = 2'h1;
	localparam logic [1:0] DIV_BY2 = 2'h2;
	localparam logic [1:0] DIV_BY1 = 2'h3;

	// ------------------------------------------------------------
	// Approximation register
	// ------------------------------------------------------------
	localparam logic [9:0] SAR_INIT = 10'h200;
	localparam logic [3:0] SAR_MSB = 4'h9;
	localparam logic [3:0] SAR_LAST_10BIT = 4'h0;
	localparam logic [3:0] SAR_LAST_8BIT = 4'h2;
	localparam logic [2:0] LAST_CH = 3'h7;
	localparam logic [9:0] RESULT_RESET = 10'h000;

	// ------------------------------------------------------------
	// Bus responses
	// ------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Reference in units of full reference / 2048: 2n-1, zero for code 0
	function automatic logic [10:0] ref_of(input logic [9:0] code);
		ref_of = (code == 10'h000) ? 11'h000 : 11'({code, 1'b0} - 11'h001);
	endfunction

endpackage
`default_nettype wire

// ==== logic/adss_sar_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface adss_sar_if;
	logic tick;
	logic start;
	logic abort;
	logic [3:0] last_bit;
	logic cmp_below;
	logic busy;
	logic done;
	logic [9:0] code;
	logic [10:0] ref_level;

	modport ctrl(output tick, output start, output abort, output last_bit, output cmp_below,
		input busy, input done, input code, input ref_level);
	modport sar(input tick, input start, input abort, input last_bit, input cmp_below,
		output busy, output done, output code, output ref_level);
endinterface
`default_nettype wire

// ==== logic/adss_clk_div.sv ====
`timescale 1ns/100ps
`default_nettype none
module adss_clk_div (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Divider choice and converter tick
	input wire logic [1:0] div_sel,
	output logic tick
);
	logic [1:0] cnt;
	logic [1:0] term;

	always_comb begin
		case (div_sel)
			adss_pkg::DIV_BY4: term = 2'h3;
			adss_pkg::DIV_BY3: term = 2'h2;
			adss_pkg::DIV_BY2: term = 2'h1;
			default: term = 2'h0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt <= 2'h0;
			tick <= 1'b0;
		end else if (cnt >= term) begin
			cnt <= 2'h0;
			tick <= 1'b1;
		end else begin
			cnt <= cnt + 2'h1;
			tick <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ==== logic/adss_sar.sv ====
`timescale 1ns/100ps
`default_nettype none
module adss_sar (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Sequencer side
	adss_sar_if.sar sif
);
	logic [3:0] bit_idx;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sif.busy <= 1'b0;
			sif.done <= 1'b0;
			sif.code <= 10'h000;
			sif.ref_level <= 11'h000;
			bit_idx <= adss_pkg::SAR_MSB;
		end else begin
			sif.done <= 1'b0;
			if (sif.abort) begin
				sif.busy <= 1'b0;
			end else if (sif.start) begin
				sif.busy <= 1'b1;
				sif.code <= adss_pkg::SAR_INIT;
				sif.ref_level <= adss_pkg::ref_of(adss_pkg::SAR_INIT);
				bit_idx <= adss_pkg::SAR_MSB;
			end else if (sif.busy && sif.tick) begin
				// Trial bit stays only when the reference is below the input
				sif.code[bit_idx] <= sif.cmp_below;
				if (bit_idx == sif.last_bit) begin
					sif.busy <= 1'b0;
					sif.done <= 1'b1;
				end else begin
					sif.code[bit_idx - 4'h1] <= 1'b1;
					sif.ref_level <= adss_pkg::ref_of((sif.code
						& ~(10'h001 << bit_idx)) | ({9'h000, sif.cmp_below} << bit_idx)
						| (10'h001 << (bit_idx - 4'h1)));
					bit_idx <= bit_idx - 4'h1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ==== logic/adss_top.sv ====
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module adss_top (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic [adss_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [adss_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Analog front end
	output logic [2:0] analog_channel,
	output logic [10:0] ref_level,
	input wire logic cmp_ref_below_input,
	// Completion flag and reference connect
	output logic conv_irq_req,
	output logic ref_connect
);
	typedef enum logic [0:0] {ST_IDLE, ST_CONVERT} adss_state_t;

	adss_sar_if sif();

	adss_state_t state;
	logic [adss_pkg::CTRL_W-1:0] ctrl;
	logic start_flag;
	logic [9:0] result [0:7];
	logic [adss_pkg::ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic aw_got;
	logic w_got;
	logic wr_fire;
	logic wr_ctrl;
	logic wr_status;
	logic wr_ok;
	logic [31:0] next_rdata;
	logic next_rok;
	logic [1:0] mode;
	logic [1:0] group_sel;
	logic res_10bit;
	logic [2:0] group_last;
	logic [2:0] rot_first;
	logic [2:0] rot_ch;
	logic in_extra;
	logic [2:0] next_ch;
	logic next_extra;
	logic sweep_end;
	logic [9:0] conv_value;
	logic div_tick;
	logic [31:0] ctrl_mask;

	// ------------------------------------------------------------
	// Control fields
	// ------------------------------------------------------------
	assign mode = ctrl[adss_pkg::CTRL_MODE_POS +: 2];
	assign group_sel = {ctrl[adss_pkg::CTRL_SEL_HI_POS], ctrl[adss_pkg::CTRL_SEL_LO_POS]};
	assign res_10bit = ctrl[adss_pkg::CTRL_RES_POS];

	always_comb begin
		// Priority group in repeat 1, full pairs otherwise
		if (mode == adss_pkg::MODE_REPEAT1) begin
			group_last = {1'b0, group_sel};
		end else begin
			group_last = {group_sel, 1'b1};
		end
	end
	assign rot_first = group_last + 3'h1;

	// ------------------------------------------------------------
	// Converter clock and approximation engine
	// ------------------------------------------------------------
	adss_clk_div u_div (
		.aclk(aclk),
		.aresetn(aresetn),
		.div_sel(ctrl[adss_pkg::CTRL_DIV_POS +: 2]),
		.tick(div_tick)
	);

	adss_sar u_sar (
		.aclk(aclk),
		.aresetn(aresetn),
		.sif(sif)
	);

	assign sif.tick = div_tick;
	assign sif.cmp_below = cmp_ref_below_input;
	assign sif.last_bit = res_10bit ? adss_pkg::SAR_LAST_10BIT : adss_pkg::SAR_LAST_8BIT;
	assign ref_level = sif.ref_level;
	assign conv_value = res_10bit ? sif.code : {2'h0, sif.code[9:2]};

	// ------------------------------------------------------------
	// Sweep order
	// ------------------------------------------------------------
	always_comb begin
		next_ch = 3'h0;
		next_extra = 1'b0;
		sweep_end = 1'b0;
		case (mode)
			adss_pkg::MODE_REPEAT0: begin
				next_ch = (analog_channel == group_last) ? 3'h0 : analog_channel + 3'h1;
			end
			adss_pkg::MODE_REPEAT1: begin
				if (in_extra) begin
					next_ch = 3'h0;
				end else if (analog_channel == group_last) begin
					next_ch = rot_ch;
					next_extra = 1'b1;
				end else begin
					next_ch = analog_channel + 3'h1;
				end
			end
			default: begin
				sweep_end = (analog_channel == group_last);
				next_ch = analog_channel + 3'h1;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_IDLE;
			analog_channel <= 3'h0;
			in_extra <= 1'b0;
			rot_ch <= 3'h0;
			sif.start <= 1'b0;
			sif.abort <= 1'b0;
		end else begin
			sif.start <= 1'b0;
			sif.abort <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (start_flag) begin
						analog_channel <= 3'h0;
						in_extra <= 1'b0;
						rot_ch <= rot_first;
						sif.start <= 1'b1;
						state <= ST_CONVERT;
					end
				end
				ST_CONVERT: begin
					if (!start_flag) begin
						// Drop the half-done code; results keep their last full value
						sif.abort <= 1'b1;
						state <= ST_IDLE;
					end else if (sif.done) begin
						if (sweep_end) begin
							state <= ST_IDLE;
						end else begin
							analog_channel <= next_ch;
							in_extra <= next_extra;
							sif.start <= 1'b1;
						end
						if (in_extra) begin
							rot_ch <= (rot_ch == adss_pkg::LAST_CH) ? rot_first : rot_ch + 3'h1;
						end
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Result registers
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < 8; i++) begin
				result[i] <= adss_pkg::RESULT_RESET;
			end
		end else if (state == ST_CONVERT && start_flag && sif.done) begin
			result[analog_channel] <= conv_value;
		end
	end

	// ------------------------------------------------------------
	// Start flag and completion flag
	// ------------------------------------------------------------
	assign wr_fire = aw_got && w_got && !s_axi_bvalid;
	assign wr_ctrl = wr_fire && awaddr_q == adss_pkg::OFF_CTRL;
	assign wr_status = wr_fire && awaddr_q == adss_pkg::OFF_STATUS;
	assign wr_ok = wr_ctrl || wr_status || awaddr_q[7:5] == adss_pkg::RESULT_PAGE;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			start_flag <= 1'b0;
		end else if (wr_ctrl && wstrb_q[0]) begin
			// Software write beats the end-of-sweep clear
			start_flag <= wdata_q[adss_pkg::CTRL_START_POS];
		end else if (state == ST_CONVERT && start_flag && sif.done && sweep_end) begin
			start_flag <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			conv_irq_req <= 1'b0;
		end else if (state == ST_CONVERT && start_flag && sif.done && sweep_end) begin
			conv_irq_req <= 1'b1;
		end else if (wr_status && wstrb_q[0] && !wdata_q[adss_pkg::STAT_IRQ_POS]) begin
			conv_irq_req <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------
	always_comb begin
		for (int b = 0; b < 4; b++) begin
			ctrl_mask[8*b +: 8] = {8{wstrb_q[b]}};
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= adss_pkg::CTRL_RESET;
			ref_connect <= 1'b0;
		end else if (wr_ctrl) begin
			ctrl <= (ctrl & ~ctrl_mask[adss_pkg::CTRL_W-1:0])
				| (wdata_q[adss_pkg::CTRL_W-1:0] & ctrl_mask[adss_pkg::CTRL_W-1:0]);
			if (wstrb_q[1]) begin
				ref_connect <= wdata_q[adss_pkg::CTRL_VREF_POS];
			end
		end
	end

	// ------------------------------------------------------------
	// Bus write channels
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= adss_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got <= 1'b1;
				awaddr_q <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				// Results are read-only: writes there are ignored but answered OKAY
				aw_got <= 1'b0;
				w_got <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? adss_pkg::RESP_OKAY : adss_pkg::RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Bus read channel
	// ------------------------------------------------------------
	always_comb begin
		next_rdata = 32'h0000_0000;
		next_rok = 1'b1;
		if (s_axi_araddr == adss_pkg::OFF_CTRL) begin
			next_rdata[adss_pkg::CTRL_W-1:0] = ctrl;
			next_rdata[adss_pkg::CTRL_START_POS] = start_flag;
			next_rdata[adss_pkg::CTRL_VREF_POS] = ref_connect;
		end else if (s_axi_araddr == adss_pkg::OFF_STATUS) begin
			next_rdata[adss_pkg::STAT_IRQ_POS] = conv_irq_req;
			next_rdata[adss_pkg::STAT_BUSY_POS] = (state == ST_CONVERT);
			next_rdata[adss_pkg::STAT_CH_POS +: 3] = analog_channel;
		end else if (s_axi_araddr[7:5] == adss_pkg::RESULT_PAGE && s_axi_araddr[1:0] == 2'h0) begin
			next_rdata[9:0] = result[s_axi_araddr[4:2]];
		end else begin
			next_rok = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= adss_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rok ? adss_pkg::RESP_OKAY : adss_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ==== tb/adss_analog_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module adss_analog_model (
	// Converter outputs
	input wire logic [2:0] analog_channel,
	input wire logic [10:0] ref_level,
	// Held level of each channel, full reference / 2048 units
	input wire logic [7:0][10:0] sampled_input_level,
	// Comparator answer
	output logic cmp_ref_below_input
);
	// Ideal comparator: no noise near the threshold, so codes are exact
	assign cmp_ref_below_input = ref_level < sampled_input_level[analog_channel];
endmodule
`default_nettype wire

// ==== tb/adss_top_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
module adss_checker (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus writes
	input wire logic [adss_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	// Converter side
	input wire logic [2:0] analog_channel,
	input wire logic [10:0] ref_level,
	input wire logic conv_irq_req
);
	// ----
	// Shadow of the control register
	// ----
	logic aw_got;
	logic w_got;
	logic [7:0] aw_a;
	logic [31:0] w_d;
	logic [8:0] ctl;
	logic [2:0] top_ch;
	logic [3:0] age;
	wire aw_now = aw_got || (s_axi_awvalid && s_axi_awready);
	wire w_now = w_got || (s_axi_wvalid && s_axi_wready);
	wire [7:0] a_now = aw_got ? aw_a : s_axi_awaddr;
	wire [31:0] d_now = w_got ? w_d : s_axi_wdata;
	wire ctl_wr = aw_now && w_now && a_now == adss_pkg::OFF_CTRL;
	wire go = ctl_wr && d_now[0];
	wire [2:0] sel = {1'b0, ctl[4:3]};
	wire rep1 = ctl[2:1] == adss_pkg::MODE_REPEAT1;
	// Ignore the jump from the idle channel right after a start
	wire run = ctl[0] && age == 4'hF;

	always_ff @(posedge aclk) begin
		aw_a <= a_now;
		w_d <= d_now;
		if (!aresetn) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			ctl <= 9'h000;
		end else begin
			aw_got <= aw_now && !w_now;
			w_got <= w_now && !aw_now;
			if (ctl_wr) begin
				ctl <= d_now[8:0];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || go) begin
			top_ch <= 3'h0;
			age <= 4'h0;
		end else begin
			if (age > 4'h2 && analog_channel > top_ch) begin
				top_ch <= analog_channel;
			end
			if (age != 4'hF) begin
				age <= age + 4'h1;
			end
		end
	end

	// ----
	// Properties
	// ----
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_REF_CODE: assert property (ref_level == 11'h000 || ref_level[0])
		else $error("Reference level neither zero nor odd");
	AST_PRELOAD: assert property ($changed(analog_channel) && analog_channel != 3'h0 |-> ##[0:6] ref_level == 11'h3FF)
		else $error("Channel conversion did not begin at mid scale");
	AST_SAR_STEP: assert property ($past(ref_level) == 11'h3FF && $changed(ref_level)
		|-> ref_level inside {11'h5FF, 11'h1FF})
		else $error("Second trial step has a wrong reference");
	AST_START_CH0: assert property (go |-> ##3 (analog_channel == 3'h0) [*6])
		else $error("Sweep did not begin at channel 0");
	AST_SINGLE_END: assert property ($rose(conv_irq_req) |-> top_ch == {ctl[4:3], 1'b1})
		else $error("Completion flag before the last group channel");
	AST_NO_IRQ_REP: assert property ($rose(conv_irq_req)
		|-> ctl[2:1] != adss_pkg::MODE_REPEAT0 && !rep1)
		else $error("Completion flag raised in a repeat sweep");
	AST_SWEEP_NEXT: assert property (run && !rep1 && $changed(analog_channel)
		&& analog_channel != 3'h0 |-> analog_channel == $past(analog_channel) + 3'h1)
		else $error("Sweep skipped a channel");
	AST_REP1_PRIO: assert property (run && rep1 && $changed(analog_channel)
		&& $past(analog_channel) < sel |-> analog_channel == $past(analog_channel) + 3'h1)
		else $error("Priority pass skipped a channel");
	AST_REP1_EXTRA: assert property (run && rep1 && $changed(analog_channel)
		&& $past(analog_channel) == sel |-> analog_channel > sel)
		else $error("No unselected channel after priority pass");
	AST_REP1_RETURN: assert property (run && rep1 && $changed(analog_channel)
		&& $past(analog_channel) > sel |-> analog_channel == 3'h0)
		else $error("No return to channel 0 after extra channel");

	cover property ($rose(conv_irq_req));
	cover property (run && rep1 && analog_channel == 3'h7);
	cover property ($past(ref_level) == 11'h3FF && ref_level == 11'h5FF);
endmodule

bind adss_top adss_checker adss_checker_i (
	.aclk(aclk),
	.aresetn(aresetn),
	.s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata),
	.s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready),
	.analog_channel(analog_channel),
	.ref_level(ref_level),
	.conv_irq_req(conv_irq_req)
);
`default_nettype wire

// ==== tb/tb_adss_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_adss_top;
	logic aclk, aresetn, cmp_ref_below_input, conv_irq_req, ref_connect;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [2:0] analog_channel;
	logic [10:0] ref_level;
	logic [7:0][10:0] sampled_input_level;
	logic [9:0] exp_res [8];
	int bad_count = 0;
	int comparisons = 0;
	int cyc = 0;

	adss_top adss_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .analog_channel(analog_channel), .ref_level(ref_level),
		.cmp_ref_below_input(cmp_ref_below_input), .conv_irq_req(conv_irq_req), .ref_connect(ref_connect));
	adss_analog_model adss_analog_model_i (.analog_channel(analog_channel), .ref_level(ref_level),
		.sampled_input_level(sampled_input_level), .cmp_ref_below_input(cmp_ref_below_input));

	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			bad_count++;
			results();
		end
	end

	task automatic results;
		$display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// ----
	// Bus tasks
	// ----
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit aw;
		bit w;
		aw = 1'b0;
		w = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge aclk);
			if (!aw && s_axi_awready) begin
				aw = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w && s_axi_wready) begin
				w = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic rd_reg(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		rd = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask

	function automatic logic [31:0] cw(input logic st, input logic [1:0] md, input logic [1:0] sel,
		input logic rs, input logic [1:0] dv);
		cw = {23'h0, 1'b1, dv, rs, sel, md, st};
	endfunction

	function automatic logic [9:0] code_of(input int s, input int c);
		code_of = 10'((s * 97 + c * 113 + 5) % 1024);
	endfunction

	task automatic set_levels(input int s);
		for (int c = 0; c < 8; c++) sampled_input_level[c] <= {code_of(s, c), 1'b0};
	endtask

	task automatic chk_results;
		for (int c = 0; c < 8; c++) begin
			rd_reg(8'(adss_pkg::OFF_RESULT0 + 4 * c));
			`CHK(rd, {22'h0, exp_res[c]})
		end
	endtask

	// ----
	// Scenarios
	// ----
	task automatic t_reset;
		for (int c = 0; c < 8; c++) exp_res[c] = adss_pkg::RESULT_RESET;
		rd_reg(adss_pkg::OFF_CTRL);
		`CHK(rd, 32'h0000_0000)
		rd_reg(8'h10);
		`CHK(resp, adss_pkg::RESP_SLVERR)
		chk_results();
		wr(8'h10, 32'h0000_0000);
		`CHK(resp, adss_pkg::RESP_SLVERR)
		wr(adss_pkg::OFF_CTRL, cw(1'b0, adss_pkg::MODE_SINGLE, 2'h0, 1'b1, adss_pkg::DIV_BY1));
		`CHK(resp, adss_pkg::RESP_OKAY)
		repeat (200) @(posedge aclk);
		`CHK(ref_connect, 1'b1)
		$display("Test done: reset and map");
	endtask

	task automatic single(input int g, input logic rs, input logic [1:0] dv, input int d);
		int t0;
		int n;
		int b;
		n = 2 * (g + 1);
		b = rs ? 10 : 8;
		set_levels(g + 10 * rs);
		wr(adss_pkg::OFF_CTRL, cw(1'b1, adss_pkg::MODE_SINGLE, 2'(g), rs, dv));
		t0 = cyc;
		do rd_reg(adss_pkg::OFF_STATUS); while (!rd[adss_pkg::STAT_IRQ_POS]);
		`CHK((cyc - t0) inside {[n * b * d - 8:n * (b * d + 4) + 30]}, 1'b1)
		`CHK(conv_irq_req, 1'b1)
		rd_reg(adss_pkg::OFF_CTRL);
		`CHK(rd[adss_pkg::CTRL_START_POS], 1'b0)
		for (int c = 0; c < n; c++) exp_res[c] = rs ? code_of(g + 10, c) : 10'(code_of(g, c) >> 2);
		chk_results();
		wr(adss_pkg::OFF_STATUS, 32'h0000_0000);
		`CHK(conv_irq_req, 1'b0)
		$display("Test done: single sweep group %0d resolution %0d", g, rs);
	endtask

	task automatic t_repeat0;
		for (int s = 5; s < 7; s++) begin
			set_levels(s);
			if (s == 5) wr(adss_pkg::OFF_CTRL, cw(1'b1, adss_pkg::MODE_REPEAT0, 2'h1, 1'b1, adss_pkg::DIV_BY1));
			repeat (300) @(posedge aclk);
			`CHK(conv_irq_req, 1'b0)
			for (int c = 0; c < 4; c++) exp_res[c] = code_of(s, c);
			chk_results();
		end
		wr(adss_pkg::OFF_CTRL, cw(1'b0, adss_pkg::MODE_REPEAT0, 2'h1, 1'b1, adss_pkg::DIV_BY1));
		repeat (4) @(posedge aclk);
		rd_reg(adss_pkg::OFF_STATUS);
		`CHK(rd[adss_pkg::STAT_BUSY_POS], 1'b0)
		set_levels(7);
		repeat (200) @(posedge aclk);
		chk_results();
		$display("Test done: repeat sweep 0");
	endtask

	task automatic t_repeat1(input int s);
		logic [2:0] prev;
		logic [2:0] want [$];
		for (int i = 0; i <= 7 - s; i++) begin
			for (int c = 1; c <= s; c++) want.push_back(3'(c));
			want.push_back(3'(s + 1 + i % (7 - s)));
			want.push_back(3'h0);
		end
		wr(adss_pkg::OFF_CTRL, cw(1'b1, adss_pkg::MODE_REPEAT1, 2'(s), 1'b1, adss_pkg::DIV_BY1));
		`CHK(analog_channel, 3'h0)
		prev = 3'h0;
		foreach (want[k]) begin
			do @(posedge aclk); while (analog_channel === prev);
			`CHK(analog_channel, want[k])
			`CHK(conv_irq_req, 1'b0)
			prev = analog_channel;
		end
		wr(adss_pkg::OFF_CTRL, cw(1'b0, adss_pkg::MODE_REPEAT1, 2'(s), 1'b1, adss_pkg::DIV_BY1));
		$display("Test done: repeat sweep 1 priority group %0d", s + 1);
	endtask

	initial begin
		aresetn = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		sampled_input_level = '0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset();
		// Divider per scenario stands in for the source-to-converter clock ratio
		for (int g = 0; g < 4; g++) single(g, 1'b1, 2'(g), 4 - g);
		single(3, 1'b0, adss_pkg::DIV_BY1, 1);
		t_repeat0();
		for (int s = 0; s < 4; s++) t_repeat1(s);
		results();
	end
endmodule
`default_nettype wire
